/* rtl/iovr_response.sv */
// input over-voltage warning fault-response controller
// limitation: only a rising warning starts a reaction, so a warning that
// stays high through a clear is not acted on again until it falls and rises
`timescale 1ns/1ps
`include "iovr_cfg.svh"
module iovr_response
    import iovr_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [7:0] rd_addr_in,
    input wire logic [`IOVR_UNIT_W-1:0] unit_cycles_in,
    input wire logic warn_in,
    input wire logic clear_in,
    input wire logic cmd_on_in,
    input wire logic other_fault_in,
    output logic [7:0] rd_data_out,
    output logic output_enable_out,
    output logic latched_off_out,
    output logic warn_active_out
);
    // ----------------------------------------
    // configuration register
    // ----------------------------------------
    // one byte holds the whole reaction: response, retry count and delay code
    logic [7:0] action_reg;
    logic warn_prev_reg;
    logic on_prev_reg;
    iovr_state_t state_reg, state_next;
    logic [2:0] tries_reg, tries_next;
    logic timer_start;
    logic timer_done;

    wire action_hit = wr_en_in && (wr_addr_in == `IOVR_ACTION_OFFSET);
    wire [1:0] resp_field = action_reg[`IOVR_RESP_HI:`IOVR_RESP_LO];
    wire [2:0] retry_field = action_reg[`IOVR_RETRY_HI:`IOVR_RETRY_LO];
    wire [2:0] delay_field = action_reg[`IOVR_DELAY_HI:`IOVR_DELAY_LO];
    wire warn_rise = warn_in && !warn_prev_reg;
    // off-then-on command: rising edge of cmd_on clears a latched fault
    wire on_rise = cmd_on_in && !on_prev_reg;
    // a status-bit clear and a fault-clear command arrive merged on clear_in
    wire clear_any = clear_in || on_rise;
    wire retry_forever = (retry_field == `IOVR_RETRY_FOREVER);
    // attempts left
    // three bits cannot wrap here: finite limits stop after at most six attempts
    wire [2:0] tries_inc = tries_reg + 3'h1;
    wire retry_left = retry_forever || (tries_inc < retry_field);
    wire [7:0] rd_next = (rd_addr_in == `IOVR_ACTION_OFFSET) ? action_reg : 8'h00;

    // register write
    // writes to any other command code fall through untouched
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            action_reg <= `IOVR_ACTION_RESET;
        end else if (action_hit) begin
            action_reg <= wr_data_in;
        end
    end

    // ----------------------------------------
    // delay timer
    // ----------------------------------------
    // limitation: the done pulse is registered, so each timed wait ends one
    // cycle after its last unit; negligible against any real time unit
    // power-of-two units
    iovr_unit_timer u_timer (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .start_in(timer_start),
        .exp_in(delay_field),
        .unit_cycles_in(unit_cycles_in),
        .done_out(timer_done)
    );

    // ----------------------------------------
    // response state machine
    // ----------------------------------------
    // next state; the timer is started on every entry to a timed state
    always_comb begin
        state_next = state_reg;
        tries_next = tries_reg;
        timer_start = 1'b0;
        case (state_reg)
            IOVR_RUN: begin
                if (warn_rise) begin
                    case (iovr_resp_t'(resp_field))
                        IOVR_RESP_IGNORE: state_next = IOVR_RUN;
                        IOVR_RESP_DELAY: begin
                            state_next = IOVR_GRACE;
                            timer_start = 1'b1;
                        end
                        IOVR_RESP_RETRY: begin
                            tries_next = 3'h0;
                            state_next = (retry_field == `IOVR_RETRY_NONE) ?
                                IOVR_LATCHED : IOVR_OFF_WAIT;
                            timer_start = 1'b1;
                        end
                        IOVR_RESP_LATCH: state_next = IOVR_LATCHED;
                        default: state_next = IOVR_RUN;
                    endcase
                end
            end
            IOVR_GRACE: begin
                // the warning is judged again only when the delay runs out
                // act only if still present
                if (timer_done) begin
                    tries_next = 3'h0;
                    if (!warn_in) begin
                        state_next = IOVR_RUN;
                    end else if (retry_field == `IOVR_RETRY_NONE) begin
                        state_next = IOVR_LATCHED;
                    end else begin
                        state_next = IOVR_OFF_WAIT;
                        timer_start = 1'b1;
                    end
                end
            end
            IOVR_OFF_WAIT: begin
                // a clear in this state is taken after the case and wins
                // stop on command off or other fault
                if (!cmd_on_in || other_fault_in) begin
                    state_next = IOVR_LATCHED;
                end else if (timer_done) begin
                    state_next = IOVR_RESTART;
                end
            end
            IOVR_RESTART: begin
                // the output is on for this one cycle; a quiet warning means success
                // count attempts
                if (!retry_forever) begin
                    tries_next = tries_inc;
                end
                if (!warn_in) begin
                    state_next = IOVR_RUN;
                end else if (retry_left) begin
                    state_next = IOVR_OFF_WAIT;
                    timer_start = 1'b1;
                end else begin
                    state_next = IOVR_LATCHED;
                end
            end
            IOVR_LATCHED: begin
                // cleared only by clear or off-on
                if (clear_any) begin
                    state_next = IOVR_RUN;
                end
            end
            default: state_next = IOVR_RUN;
        endcase
        // a pending clear also ends a retry sequence
        if (clear_in && (state_reg == IOVR_OFF_WAIT)) begin
            state_next = IOVR_RUN;
        end
    end

    // state and edge history
    // the on command idles high, so its history resets high: no false off-on edge
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= IOVR_RUN;
            tries_reg <= 3'h0;
            warn_prev_reg <= 1'b0;
            on_prev_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            tries_reg <= tries_next;
            warn_prev_reg <= warn_in;
            on_prev_reg <= cmd_on_in;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // output decode from the next state, so each status port comes straight from a
    // flop in step with the state register, with no added cycle of latency and no decode path to the pins
    wire next_is_on = (state_next == IOVR_RUN) || (state_next == IOVR_GRACE) ||
        (state_next == IOVR_RESTART);
    // the stage only runs while the on command stands; a dropped command wins
    wire enable_next = cmd_on_in && next_is_on;
    wire latched_next = (state_next == IOVR_LATCHED);
    wire active_next = (state_next != IOVR_RUN);

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_data_out <= 8'h00;
            output_enable_out <= 1'b0;
            latched_off_out <= 1'b0;
            warn_active_out <= 1'b0;
        end else begin
            rd_data_out <= rd_next;
            output_enable_out <= enable_next;
            latched_off_out <= latched_next;
            warn_active_out <= active_next;
        end
    end
endmodule

/* rtl/iovr_cfg.svh */
// constants for the input over-voltage warning response block
`ifndef IOVR_CFG_SVH
`define IOVR_CFG_SVH
// ----------------------------------------
// register map and fields
// ----------------------------------------
`define IOVR_ACTION_OFFSET 8'hC4
`define IOVR_ACTION_RESET 8'h00
`define IOVR_RESP_HI 7
`define IOVR_RESP_LO 6
`define IOVR_RETRY_HI 5
`define IOVR_RETRY_LO 3
`define IOVR_DELAY_HI 2
`define IOVR_DELAY_LO 0
`define IOVR_RETRY_NONE 3'h0
`define IOVR_RETRY_FOREVER 3'h7
// ----------------------------------------
// timing
// ----------------------------------------
`define IOVR_UNIT_W 16
`define IOVR_UNIT_CNT_RESET 16'h00FA
`endif

/* rtl/iovr_pkg.sv */
// types for the input over-voltage warning response block
package iovr_pkg;
    typedef enum logic [1:0] {
        IOVR_RESP_IGNORE,
        IOVR_RESP_DELAY,
        IOVR_RESP_RETRY,
        IOVR_RESP_LATCH
    } iovr_resp_t;
    typedef enum logic [2:0] {
        IOVR_RUN,
        IOVR_GRACE,
        IOVR_OFF_WAIT,
        IOVR_RESTART,
        IOVR_LATCHED
    } iovr_state_t;
endpackage

/* rtl/iovr_unit_timer.sv */
// delay timer counting 2^n time units of a programmable cycle length
`timescale 1ns/1ps
`include "iovr_cfg.svh"
module iovr_unit_timer (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic start_in,
    input wire logic [2:0] exp_in,
    input wire logic [`IOVR_UNIT_W-1:0] unit_cycles_in,
    output logic done_out
);
    logic [`IOVR_UNIT_W-1:0] tick_reg;
    logic [7:0] units_reg;
    logic run_reg;
    wire unit_end = (tick_reg == unit_cycles_in) || (unit_cycles_in == 16'h0000);
    // ----------------------------------------
    // counters
    // ----------------------------------------
    // restart on start_in; one-cycle done when the last unit ends
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tick_reg <= 16'h0000;
            units_reg <= 8'h00;
            run_reg <= 1'b0;
            done_out <= 1'b0;
        end else if (start_in) begin
            tick_reg <= 16'h0001;
            units_reg <= 8'(8'h01 << exp_in);
            run_reg <= 1'b1;
            done_out <= 1'b0;
        end else if (run_reg && unit_end) begin
            tick_reg <= 16'h0001;
            units_reg <= units_reg - 8'h01;
            run_reg <= (units_reg != 8'h01);
            done_out <= (units_reg == 8'h01);
        end else begin
            tick_reg <= run_reg ? tick_reg + 16'h0001 : tick_reg;
            done_out <= 1'b0;
        end
    end
endmodule

/* testbench/iovr_response_asserts.sv */
// concurrent checks on the warning response ports
`timescale 1ns/1ps
module iovr_response_asserts (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [7:0] rd_addr_in,
    input wire logic warn_in,
    input wire logic clear_in,
    input wire logic cmd_on_in,
    input wire logic [7:0] rd_data_out,
    input wire logic output_enable_out,
    input wire logic latched_off_out,
    input wire logic warn_active_out
);
    logic [7:0] cfg_q;
    // shadow of the action byte, rebuilt from the write port alone
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_q <= 8'h00;
        end else if (wr_en_in && wr_addr_in == 8'hC4) begin
            cfg_q <= wr_data_in;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // fresh warning while running normally
    sequence s_hit;
        $rose(warn_in) && output_enable_out && !warn_active_out && cmd_on_in && !clear_in;
    endsequence
    // ----
    // reactions
    // ----
    AST_IGNORE: assert property (s_hit ##0 cfg_q[7:6] == 2'h0 |=>
        output_enable_out && !warn_active_out) else $error("ignore interrupted");
    AST_GRACE: assert property (s_hit ##0 cfg_q[7:6] == 2'h1 |=>
        output_enable_out && warn_active_out) else $error("grace stopped");
    AST_DROP: assert property (s_hit ##0 cfg_q[7:6] == 2'h2 |=>
        !output_enable_out && warn_active_out) else $error("no drop");
    AST_LATCH: assert property (s_hit ##0 cfg_q[7:6] == 2'h3 |=>
        latched_off_out && !output_enable_out) else $error("no latch");
    AST_OFF: assert property (latched_off_out |-> !output_enable_out)
        else $error("on while latched");
    AST_CLEAR: assert property (latched_off_out && clear_in && cmd_on_in |=>
        !latched_off_out && output_enable_out) else $error("clear ignored");
    AST_HOLD: assert property (latched_off_out && !clear_in && !$rose(cmd_on_in) |=>
        latched_off_out) else $error("latch lost");
    AST_READ: assert property (rd_addr_in == 8'hC4 && !wr_en_in |=>
        rd_data_out == cfg_q) else $error("bad readback");
    AST_READ_NONE: assert property (rd_addr_in != 8'hC4 |=>
        rd_data_out == 8'h00) else $error("unmapped read");
endmodule
bind iovr_response iovr_response_asserts u_asserts (.clk_in(clk_in), .reset_in(reset_in),
    .wr_en_in(wr_en_in), .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in),
    .rd_addr_in(rd_addr_in), .warn_in(warn_in), .clear_in(clear_in), .cmd_on_in(cmd_on_in),
    .rd_data_out(rd_data_out), .output_enable_out(output_enable_out),
    .latched_off_out(latched_off_out), .warn_active_out(warn_active_out));

/* testbench/iovr_host_model.sv */
// host model issuing register writes, reads and fault clears
`timescale 1ns/1ps
module iovr_host_model (
    input wire logic clk_in,
    input wire logic [7:0] rd_data_in,
    output logic wr_en_out,
    output logic [7:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    output logic [7:0] rd_addr_out,
    output logic clear_out
);
    // idle values at time zero
    initial begin
        wr_en_out = 1'b0;
        wr_addr_out = 8'h00;
        wr_data_out = 8'h00;
        rd_addr_out = 8'h00;
        clear_out = 1'b0;
    end
    // released lines show the inverse so stale data never passes
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        wr_en_out = 1'b1;
        wr_addr_out = a;
        wr_data_out = d;
        @(posedge clk_in);
        #1;
        wr_en_out = 1'b0;
        wr_addr_out = ~a;
        wr_data_out = ~d;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        rd_addr_out = a;
        @(posedge clk_in);
        #1;
        d = rd_data_in;
    endtask
    task automatic clear_pulse();
        @(posedge clk_in);
        #1;
        clear_out = 1'b1;
        @(posedge clk_in);
        #1;
        clear_out = 1'b0;
    endtask
endmodule

/* testbench/iovr_response_bench.sv */
// self-checking bench for the warning response block
`timescale 1ns/1ps
module iovr_response_bench;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic warn_in = 1'b0;
    logic cmd_on_in = 1'b1;
    logic other_fault_in = 1'b0;
    logic [15:0] unit_cycles_in = 16'h0003;
    logic wr_en_in, clear_in, output_enable_out, latched_off_out, warn_active_out;
    logic [7:0] wr_addr_in, wr_data_in, rd_addr_in, rd_data_out, v;
    int fail_count = 0;
    int num_checks = 0;
    int n, gap, sp2, t;
    // 250 MHz clock
    always #2 clk_in = ~clk_in;
    iovr_host_model u_host (.clk_in(clk_in), .rd_data_in(rd_data_out), .wr_en_out(wr_en_in),
        .wr_addr_out(wr_addr_in), .wr_data_out(wr_data_in), .rd_addr_out(rd_addr_in),
        .clear_out(clear_in));
    iovr_response u_dut (.clk_in(clk_in), .reset_in(reset_in), .wr_en_in(wr_en_in),
        .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in), .rd_addr_in(rd_addr_in),
        .unit_cycles_in(unit_cycles_in), .warn_in(warn_in), .clear_in(clear_in),
        .cmd_on_in(cmd_on_in), .other_fault_in(other_fault_in), .rd_data_out(rd_data_out),
        .output_enable_out(output_enable_out), .latched_off_out(latched_off_out),
        .warn_active_out(warn_active_out));
    // ----
    // helpers
    // ----
    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("FAIL t=%0t %s", $time, m);
        end
    endtask
    // counts restarts as rises of the enable, bounded by lim cycles
    task automatic watch(input int lim);
        logic p;
        n = 0;
        t = 0;
        p = output_enable_out;
        repeat (lim) begin
            tick(1);
            t++;
            if (output_enable_out && !p) begin
                n++;
                if (n == 2) gap = t;
                t = 0;
            end
            p = output_enable_out;
            if (latched_off_out === 1'b1) break;
        end
    endtask
    task automatic recover(input string s);
        warn_in = 1'b0;
        other_fault_in = 1'b0;
        u_host.clear_pulse();
        tick(3);
        chk(output_enable_out === 1'b1 && latched_off_out === 1'b0, "no run");
        $display("test %s done", s);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        tick(2);
        u_host.read(8'hC4, v);
        chk(v === 8'h00, "reset value");
        u_host.write(8'hC4, 8'h3F);
        u_host.write(8'hC5, 8'hC0);
        u_host.read(8'hC4, v);
        chk(v === 8'h3F, "readback");
        u_host.read(8'hC5, v);
        chk(v === 8'h00, "unmapped");
        $display("test registers done");
        warn_in = 1'b1;
        tick(30);
        chk(output_enable_out === 1'b1 && warn_active_out === 1'b0, "ignore");
        recover("ignore");
        u_host.write(8'hC4, 8'h42);
        warn_in = 1'b1;
        t = 0;
        repeat (100) begin
            tick(1);
            if (output_enable_out !== 1'b1) break;
            t++;
        end
        chk(t >= 12 && t <= 18, "grace length");
        tick(3);
        chk(latched_off_out === 1'b1, "grace latch");
        recover("grace");
        warn_in = 1'b1;
        tick(3);
        warn_in = 1'b0;
        tick(30);
        chk(output_enable_out === 1'b1 && warn_active_out === 1'b0, "grace back");
        u_host.write(8'hC4, 8'hC0);
        warn_in = 1'b1;
        tick(2);
        warn_in = 1'b0;
        tick(20);
        chk(latched_off_out === 1'b1, "latch hold");
        cmd_on_in = 1'b0;
        tick(2);
        cmd_on_in = 1'b1;
        tick(2);
        chk(latched_off_out === 1'b0, "off-on");
        recover("latch");
        for (int r = 0; r < 7; r++) begin
            u_host.write(8'hC4, 8'h80 | 8'(r << 3) | 8'(r % 2));
            warn_in = 1'b1;
            watch(400);
            chk(n == r && latched_off_out === 1'b1, "attempts");
            if (r == 2) sp2 = gap;
            if (r == 3) chk(gap - sp2 == 3, "spacing");
            recover("retry");
        end
        // a longer time unit stretches the retry spacing by the same amount
        unit_cycles_in = 16'h0005;
        u_host.write(8'hC4, 8'h90);
        warn_in = 1'b1;
        watch(400);
        chk(n == 2 && gap - sp2 == 5 - 3, "unit length");
        unit_cycles_in = 16'h0003;
        recover("unit");
        u_host.write(8'hC4, 8'hB8);
        warn_in = 1'b1;
        watch(300);
        chk(n > 6 && latched_off_out === 1'b0, "unlimited");
        other_fault_in = 1'b1;
        tick(2);
        watch(60);
        chk(n == 0, "fault stop");
        recover("unlimited");
        // commanding the output off during the retry wait ends the retries
        u_host.write(8'hC4, 8'hB8);
        warn_in = 1'b1;
        tick(3);
        cmd_on_in = 1'b0;
        tick(2);
        chk(latched_off_out === 1'b1 && output_enable_out === 1'b0, "off stop");
        cmd_on_in = 1'b1;
        tick(2);
        recover("commanded off");
        print_verdict();
    end
endmodule
